// ===== logic/panel_pkg.sv
package panel_pkg;

	// Key positions within the key bus.
	localparam int KEY_COUNT = 5;
	localparam int KEY_MODE  = 0;
	localparam int KEY_SET   = 1;
	localparam int KEY_UP    = 2;
	localparam int KEY_DOWN  = 3;
	localparam int KEY_SHIFT = 4;

	// Basic panel modes, visited in this order by the mode key.
	typedef enum logic [3:0] {
		MODE_STATUS  = 4'b0001,
		MODE_PARAM   = 4'b0010,
		MODE_MONITOR = 4'b0100,
		MODE_AUX     = 4'b1000
	} panel_mode_e;

	// Drive control method, one-hot on the control_mode_i port.
	localparam logic [3:0] CTRL_SPEED    = 4'b0001;
	localparam logic [3:0] CTRL_POSITION = 4'b0010;
	localparam logic [3:0] CTRL_TORQUE   = 4'b0100;
	localparam logic [3:0] CTRL_BUS      = 4'b1000;

	// Power-up display selection: this value keeps the status screen.
	localparam logic [11:0] POWERUP_STATUS      = 12'hfff;
	localparam logic [11:0] POWERUP_SEL_DEFAULT = 12'hfff;

	// Default thresholds, in rpm, mm/s, command units and percent of rated torque.
	localparam logic [15:0] SPEED_MATCH_DEFAULT   = 16'h000a;
	localparam logic [31:0] POSITION_DONE_DEFAULT = 32'h0000_0007;
	localparam logic [15:0] ROTATION_DEFAULT      = 16'h0014;
	localparam logic [15:0] TORQUE_CMD_PERCENT    = 16'h000a;

	// Panel has five digits.
	localparam int DIGIT_COUNT = 5;

	// Timing.
	localparam int CLOCK_KHZ        = 100_000;
	localparam int DEBOUNCE_TIME_MS = 10;
	localparam int DEBOUNCE_CYCLES  = DEBOUNCE_TIME_MS * CLOCK_KHZ;
	localparam int BLINK_HALF_MS    = 250;
	localparam int BLINK_CYCLES     = BLINK_HALF_MS * CLOCK_KHZ;

endpackage : panel_pkg

// ===== logic/key_if.sv
`timescale 1ns/1ns
interface key_if;
	logic [panel_pkg::KEY_COUNT-1:0] raw;
	logic [panel_pkg::KEY_COUNT-1:0] press;

	modport filter
	(
		input  raw,
		output press
	);

	modport panel
	(
		output raw,
		input  press
	);
endinterface : key_if

// ===== logic/key_debounce.sv
`timescale 1ns/1ns
module key_debounce #(
	parameter int SETTLE_CYCLES = panel_pkg::DEBOUNCE_CYCLES
)
(
	input  wire logic clock_i,
	input  wire logic rst_b_i,
	key_if.filter     keys
);

	localparam int CW = $clog2(SETTLE_CYCLES + 1);

	genvar k;
	generate
		for (k = 0; k < panel_pkg::KEY_COUNT; k++)
		begin : g_key
			logic [CW-1:0] count;
			logic          stable;

			// A key level is accepted only after it held steady for the settle time, so contact bounce
			// can never yield a second press.
			always_ff @(posedge clock_i)
			begin
				if (!rst_b_i)
				begin
					count  <= '0;
					stable <= 1'b0;
				end
				else if (keys.raw[k] == stable)
				begin
					count <= '0;
				end
				else if (count == CW'(SETTLE_CYCLES - 1))
				begin
					count  <= '0;
					stable <= keys.raw[k];
				end
				else
				begin
					count <= count + CW'(1);
				end
			end

			always_ff @(posedge clock_i)
			begin
				if (!rst_b_i)
					keys.press[k] <= 1'b0;
				else
					keys.press[k] <= (count == CW'(SETTLE_CYCLES - 1)) && keys.raw[k] && !stable;
			end

			press_single_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
				keys.press[k] |=> !keys.press[k])
				else $error("key press pulse longer than one cycle");
		end
	endgenerate

endmodule : key_debounce

// ===== logic/panel_key_and_status_display.sv
`timescale 1ns/1ns
module panel_key_and_status_display #(
	parameter int DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYCLES,
	parameter int BLINK_CYCLES    = panel_pkg::BLINK_CYCLES
)
(
	input  wire logic                                clock_i,
	input  wire logic                                rst_b_i,
	input  wire logic [panel_pkg::KEY_COUNT-1:0]     keys_i,
	input  wire logic [11:0]                         powerup_display_select_i,
	input  wire logic                                jog_aux_function_i,
	input  wire logic                                alarm_active_i,
	input  wire logic                                control_power_on_i,
	input  wire logic                                main_power_on_i,
	input  wire logic                                servo_on_i,
	input  wire logic [3:0]                          control_mode_i,
	input  wire logic                                linear_motor_i,
	input  wire logic signed [15:0]                  motor_speed_i,
	input  wire logic signed [15:0]                  speed_command_i,
	input  wire logic signed [31:0]                  position_deviation_i,
	input  wire logic signed [15:0]                  torque_command_i,
	input  wire logic [15:0]                         speed_match_threshold_rot_i,
	input  wire logic [15:0]                         speed_match_threshold_lin_i,
	input  wire logic [31:0]                         position_done_window_i,
	input  wire logic [15:0]                         rotation_detect_threshold_rot_i,
	input  wire logic [15:0]                         rotation_detect_threshold_lin_i,
	input  wire logic                                command_pulse_active_i,
	input  wire logic                                deviation_clear_i,
	input  wire logic                                command_noise_i,
	input  wire logic                                forced_stop_input_i,
	input  wire logic [1:0]                          bus_connector_a_i,
	input  wire logic [1:0]                          bus_connector_b_i,
	output panel_pkg::panel_mode_e                   panel_mode_o,
	output logic                                     param_value_shown_o,
	output logic [11:0]                              monitor_item_o,
	output logic                                     alarm_clear_o,
	output logic                                     edit_inc_o,
	output logic                                     edit_dec_o,
	output logic                                     jog_forward_o,
	output logic                                     jog_reverse_o,
	output logic [2:0]                               selected_digit_o,
	output logic [panel_pkg::DIGIT_COUNT-1:0]        digit_point_o,
	output logic                                     control_power_seg_o,
	output logic                                     power_ready_seg_o,
	output logic                                     base_block_seg_o,
	output logic                                     speed_match_flag_o,
	output logic                                     noise_minus_seg_o,
	output logic                                     position_done_flag_o,
	output logic                                     rotation_detect_flag_o,
	output logic                                     command_input_seg_o,
	output logic                                     clear_input_seg_o,
	output logic [1:0]                               bus_a_seg_o,
	output logic [1:0]                               bus_b_seg_o,
	output logic                                     forced_stop_symbol_o
);

	key_if keys_bus ();

	assign keys_bus.raw = keys_i;

	key_debounce #(
		.SETTLE_CYCLES(DEBOUNCE_CYCLES)
	) debounce (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.keys   (keys_bus.filter)
	);

	logic [panel_pkg::KEY_COUNT-1:0] press;
	assign press = keys_bus.press;

	function automatic logic [32:0] magnitude(input logic signed [32:0] v);
		magnitude = v[32] ? 33'(-v) : 33'(v);
	endfunction : magnitude

	// Mode sequencing.
	logic        powerup_pending;
	logic        jogging;
	panel_pkg::panel_mode_e next_mode;

	always_comb
	begin
		case (panel_mode_o)
			panel_pkg::MODE_STATUS:  next_mode = panel_pkg::MODE_PARAM;
			panel_pkg::MODE_PARAM:   next_mode = panel_pkg::MODE_MONITOR;
			panel_pkg::MODE_MONITOR: next_mode = panel_pkg::MODE_AUX;
			panel_pkg::MODE_AUX:     next_mode = panel_pkg::MODE_STATUS;
			default:                 next_mode = panel_pkg::MODE_STATUS;
		endcase
	end

	assign jogging = (panel_mode_o == panel_pkg::MODE_AUX) && jog_aux_function_i;

	// The selection is caught one cycle after reset release so the reset path stays constant.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			powerup_pending <= 1'b1;
		else
			powerup_pending <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			panel_mode_o <= panel_pkg::MODE_STATUS;
		else if (powerup_pending)
			panel_mode_o <= (powerup_display_select_i == panel_pkg::POWERUP_STATUS) ?
				panel_pkg::MODE_STATUS : panel_pkg::MODE_MONITOR;
		else if (press[panel_pkg::KEY_MODE])
			panel_mode_o <= next_mode;
		else if (press[panel_pkg::KEY_SET])
			panel_mode_o <= panel_pkg::MODE_PARAM;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			monitor_item_o <= 12'h000;
		else if (powerup_pending)
			monitor_item_o <= powerup_display_select_i;
	end

	// A second set press while a value is shown returns to the parameter number.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			param_value_shown_o <= 1'b0;
		else if (powerup_pending || press[panel_pkg::KEY_MODE])
			param_value_shown_o <= 1'b0;
		else if (press[panel_pkg::KEY_SET])
			param_value_shown_o <= (panel_mode_o == panel_pkg::MODE_PARAM) ? !param_value_shown_o : 1'b1;
	end

	// Key actions, one pulse per accepted press.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			alarm_clear_o <= 1'b0;
			edit_inc_o    <= 1'b0;
			edit_dec_o    <= 1'b0;
			jog_forward_o <= 1'b0;
			jog_reverse_o <= 1'b0;
		end
		else
		begin
			alarm_clear_o <= press[panel_pkg::KEY_SET] && alarm_active_i;
			edit_inc_o    <= press[panel_pkg::KEY_UP] && !jogging;
			jog_forward_o <= press[panel_pkg::KEY_UP] && jogging;
			edit_dec_o    <= press[panel_pkg::KEY_DOWN] && !jogging;
			jog_reverse_o <= press[panel_pkg::KEY_DOWN] && jogging;
		end
	end

	// Digit selection wraps from the leftmost digit back to the rightmost.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			selected_digit_o <= 3'h0;
		else if (press[panel_pkg::KEY_MODE])
			selected_digit_o <= 3'h0;
		else if (press[panel_pkg::KEY_SHIFT])
			selected_digit_o <= (selected_digit_o == 3'(panel_pkg::DIGIT_COUNT - 1)) ?
				3'h0 : selected_digit_o + 3'h1;
	end

	// Shared blink timebase for the digit point and the noise minus sign.
	logic [31:0] blink_count;
	logic        blink_phase;

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			blink_count <= 32'h0;
			blink_phase <= 1'b0;
		end
		else if (blink_count == 32'(BLINK_CYCLES - 1))
		begin
			blink_count <= 32'h0;
			blink_phase <= !blink_phase;
		end
		else
		begin
			blink_count <= blink_count + 32'h1;
		end
	end

	genvar d;
	generate
		for (d = 0; d < panel_pkg::DIGIT_COUNT; d++)
		begin : g_point
			always_ff @(posedge clock_i)
			begin
				if (!rst_b_i)
					digit_point_o[d] <= 1'b0;
				else
					digit_point_o[d] <= param_value_shown_o && (selected_digit_o == 3'(d)) && blink_phase;
			end
		end
	endgenerate

	// Status segment comparisons.
	logic        in_speed;
	logic        in_position;
	logic        in_torque;
	logic        in_bus;
	logic [32:0] speed_match_thr;
	logic [32:0] rotation_thr;
	logic [32:0] speed_err;
	logic [32:0] speed_mag;
	logic [32:0] command_mag;
	logic [32:0] deviation_mag;
	logic [32:0] torque_mag;
	logic        command_level;

	assign in_speed        = control_mode_i == panel_pkg::CTRL_SPEED;
	assign in_position     = control_mode_i == panel_pkg::CTRL_POSITION;
	assign in_torque       = control_mode_i == panel_pkg::CTRL_TORQUE;
	assign in_bus          = control_mode_i == panel_pkg::CTRL_BUS;
	assign speed_match_thr = 33'(linear_motor_i ? speed_match_threshold_lin_i : speed_match_threshold_rot_i);
	assign rotation_thr    = 33'(linear_motor_i ? rotation_detect_threshold_lin_i : rotation_detect_threshold_rot_i);
	assign speed_err       = magnitude(33'(motor_speed_i) - 33'(speed_command_i));
	assign speed_mag       = magnitude(33'(motor_speed_i));
	assign command_mag     = magnitude(33'(speed_command_i));
	assign deviation_mag   = magnitude(33'(position_deviation_i));
	assign torque_mag      = magnitude(33'(torque_command_i));

	always_comb
	begin
		if (in_speed)
			command_level = command_mag > rotation_thr;
		else if (in_position)
			command_level = command_pulse_active_i;
		else if (in_torque)
			command_level = torque_mag > 33'(panel_pkg::TORQUE_CMD_PERCENT);
		else
			command_level = 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			control_power_seg_o    <= 1'b0;
			power_ready_seg_o      <= 1'b0;
			base_block_seg_o       <= 1'b1;
			speed_match_flag_o     <= 1'b0;
			noise_minus_seg_o      <= 1'b0;
			position_done_flag_o   <= 1'b0;
			rotation_detect_flag_o <= 1'b0;
			command_input_seg_o    <= 1'b0;
			clear_input_seg_o      <= 1'b0;
			bus_a_seg_o            <= 2'h0;
			bus_b_seg_o            <= 2'h0;
			forced_stop_symbol_o   <= 1'b0;
		end
		else
		begin
			control_power_seg_o    <= control_power_on_i;
			power_ready_seg_o      <= main_power_on_i;
			base_block_seg_o       <= !servo_on_i;
			speed_match_flag_o     <= in_torque || (in_speed && speed_err <= speed_match_thr);
			noise_minus_seg_o      <= command_noise_i && blink_phase;
			position_done_flag_o   <= in_position && deviation_mag <= 33'(position_done_window_i);
			rotation_detect_flag_o <= speed_mag > rotation_thr;
			command_input_seg_o    <= command_level;
			clear_input_seg_o      <= in_position && deviation_clear_i;
			bus_a_seg_o            <= in_bus ? bus_connector_a_i : 2'h0;
			bus_b_seg_o            <= in_bus ? bus_connector_b_i : 2'h0;
			forced_stop_symbol_o   <= forced_stop_input_i;
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking

	default disable iff (!rst_b_i);

	sequence mode_key_s;
		press[panel_pkg::KEY_MODE] && !powerup_pending;
	endsequence

	sequence jog_up_s;
		press[panel_pkg::KEY_UP] && jogging;
	endsequence

	sequence jog_down_s;
		press[panel_pkg::KEY_DOWN] && jogging;
	endsequence

	mode_advance_a: assert property (mode_key_s |=> panel_mode_o != $past(panel_mode_o))
		else $error("mode key did not advance the mode");
	mode_cycle_a: assert property ((mode_key_s and (panel_mode_o == panel_pkg::MODE_AUX))
		|=> panel_mode_o == panel_pkg::MODE_STATUS)
		else $error("mode did not wrap to status");
	set_alarm_a: assert property ((press[panel_pkg::KEY_SET] && alarm_active_i) |=> alarm_clear_o)
		else $error("set key did not clear the alarm");
	set_param_a: assert property ((press[panel_pkg::KEY_SET] && !press[panel_pkg::KEY_MODE] && !powerup_pending)
		|=> panel_mode_o == panel_pkg::MODE_PARAM)
		else $error("set key did not enter parameter mode");
	jog_forward_a: assert property (jog_up_s |=> jog_forward_o && !edit_inc_o)
		else $error("up key during jog did not start forward rotation");
	up_inc_a: assert property ((press[panel_pkg::KEY_UP] && !jogging) |=> edit_inc_o && !jog_forward_o)
		else $error("up key did not increment");
	jog_reverse_a: assert property (jog_down_s |=> jog_reverse_o && !edit_dec_o)
		else $error("down key during jog did not start reverse rotation");
	shift_digit_a: assert property ((press[panel_pkg::KEY_SHIFT] && !press[panel_pkg::KEY_MODE]
		&& selected_digit_o == 3'h0) |=> selected_digit_o == 3'h1)
		else $error("shift key did not move the digit");
	powerup_view_a: assert property ($rose(rst_b_i) |=>
		(panel_mode_o == panel_pkg::MODE_STATUS) == ($past(powerup_display_select_i) == panel_pkg::POWERUP_STATUS))
		else $error("power-up display selection not honoured");
	base_block_a: assert property (servo_on_i |=> !base_block_seg_o)
		else $error("base block lit while servo on");
	torque_match_a: assert property (in_torque |=> speed_match_flag_o)
		else $error("speed match dark in torque control");
	clear_seg_a: assert property ((in_position && deviation_clear_i) ##1 deviation_clear_i |-> clear_input_seg_o)
		else $error("clear segment not lit");

endmodule : panel_key_and_status_display

// ===== dv/panel_operator_model.sv
`timescale 1ns/1ns
// Behaves like a finger on the keypad: one key at a time, held for a number
// of cycles, then released long enough for the release to settle as well.
module panel_operator_model
(
	input  wire logic                            clock_i,
	output logic [panel_pkg::KEY_COUNT-1:0]      keys_o
);
	initial keys_o = '0;

	// A short hold stands in for a contact bounce.
	task automatic press(input int key, input int hold);
		@(posedge clock_i);
		keys_o[key] <= 1'b1;
		repeat (hold) @(posedge clock_i);
		keys_o[key] <= 1'b0;
		repeat (10) @(posedge clock_i);
	endtask : press
endmodule : panel_operator_model

// ===== dv/tb_panel_key_and_status_display.sv
`timescale 1ns/1ns
module tb_panel_key_and_status_display;
	logic clk = 0, rst_b = 0, jog = 0, alarm = 0, cpow = 0, mpow = 0, servo = 0, lin = 0;
	logic pulse = 0, clr = 0, noise = 0, fstop = 0;
	logic [11:0] sel = 12'hfff;
	logic [3:0] ctrl = 4'h0;
	logic signed [15:0] spd = 0, cmd = 0, trq = 0;
	logic signed [31:0] dev = 0;
	logic [1:0] bus_a = 2'h0, bus_b = 2'h0;
	logic [31:0] pdw = 32'h0000_0007;
	logic [15:0] rtr = 16'h0014;
	logic [4:0] keys, point;
	logic [3:0] mode;
	logic [11:0] item;
	logic shown, aclr, inc, dec, fwd, rev, cps, prs, bbs, sms, nms, pds, rds, cis, cls, fss;
	logic [2:0] digit;
	logic [1:0] bas, bbo;
	int mismatches = 0, n_compared = 0, n_inc = 0, n_dec = 0, n_fwd = 0, n_rev = 0, n_clr = 0;
	bit seen0, seen1, pt0, pt1;

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		n_inc += int'(inc === 1'b1);
		n_dec += int'(dec === 1'b1);
		n_fwd += int'(fwd === 1'b1);
		n_rev += int'(rev === 1'b1);
		n_clr += int'(aclr === 1'b1);
	end

	panel_operator_model panel_operator_model_i (.clock_i(clk), .keys_o(keys));

	panel_key_and_status_display #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(4)) panel_key_and_status_display_i (
		.clock_i(clk), .rst_b_i(rst_b), .keys_i(keys), .powerup_display_select_i(sel),
		.jog_aux_function_i(jog), .alarm_active_i(alarm), .control_power_on_i(cpow),
		.main_power_on_i(mpow), .servo_on_i(servo), .control_mode_i(ctrl), .linear_motor_i(lin),
		.motor_speed_i(spd), .speed_command_i(cmd), .position_deviation_i(dev), .torque_command_i(trq),
		.speed_match_threshold_rot_i(16'h000a), .speed_match_threshold_lin_i(16'h001e),
		.position_done_window_i(pdw), .rotation_detect_threshold_rot_i(rtr),
		.rotation_detect_threshold_lin_i(16'h0005), .command_pulse_active_i(pulse),
		.deviation_clear_i(clr), .command_noise_i(noise), .forced_stop_input_i(fstop),
		.bus_connector_a_i(bus_a), .bus_connector_b_i(bus_b), .panel_mode_o(mode),
		.param_value_shown_o(shown), .monitor_item_o(item), .alarm_clear_o(aclr), .edit_inc_o(inc),
		.edit_dec_o(dec), .jog_forward_o(fwd), .jog_reverse_o(rev), .selected_digit_o(digit),
		.digit_point_o(point), .control_power_seg_o(cps), .power_ready_seg_o(prs),
		.base_block_seg_o(bbs), .speed_match_flag_o(sms), .noise_minus_seg_o(nms),
		.position_done_flag_o(pds), .rotation_detect_flag_o(rds), .command_input_seg_o(cis),
		.clear_input_seg_o(cls), .bus_a_seg_o(bas), .bus_b_seg_o(bbo), .forced_stop_symbol_o(fss)
	);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic press(input int key);
		panel_operator_model_i.press(key, 8);
		@(negedge clk);
	endtask : press

	// Input changes land on a rising edge; segments are looked at two cycles on.
	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic do_reset(input logic [11:0] value);
		@(posedge clk);
		rst_b <= 1'b0;
		sel <= value;
		repeat (5) @(posedge clk);
		@(negedge clk);
		check("base block in reset", bbs, 1);
		@(posedge clk);
		rst_b <= 1'b1;
		settle();
	endtask : do_reset

	initial
	begin
		do_reset(12'hfff);
		check("mode after power-up", mode, panel_pkg::MODE_STATUS);
		press(panel_pkg::KEY_MODE);
		check("mode 1", mode, panel_pkg::MODE_PARAM);
		press(panel_pkg::KEY_MODE);
		check("mode 2", mode, panel_pkg::MODE_MONITOR);
		press(panel_pkg::KEY_MODE);
		check("mode 3", mode, panel_pkg::MODE_AUX);
		press(panel_pkg::KEY_MODE);
		check("mode 4", mode, panel_pkg::MODE_STATUS);
		@(posedge clk);
		alarm <= 1'b1;
		press(panel_pkg::KEY_SET);
		check("set mode", mode, panel_pkg::MODE_PARAM);
		check("value shown", shown, 1);
		check("alarm clears", n_clr, 1);
		for (int i = 1; i <= 5; i++)
		begin
			press(panel_pkg::KEY_SHIFT);
			check("digit", digit, i % 5);
		end
		for (int i = 0; i < 20; i++)
		begin
			@(negedge clk);
			check("other points dark", point[4:1], 4'h0);
			pt0 |= (point[0] === 1'b0);
			pt1 |= (point[0] === 1'b1);
		end
		check("point blinks", {pt0, pt1}, 2'h3);
		press(panel_pkg::KEY_UP);
		press(panel_pkg::KEY_UP);
		press(panel_pkg::KEY_DOWN);
		check("increments", n_inc, 2);
		check("decrements", n_dec, 1);
		panel_operator_model_i.press(panel_pkg::KEY_UP, 2);
		check("bounce ignored", n_inc, 2);
		press(panel_pkg::KEY_MODE);
		press(panel_pkg::KEY_MODE);
		@(posedge clk);
		jog <= 1'b1;
		press(panel_pkg::KEY_UP);
		press(panel_pkg::KEY_DOWN);
		check("jog forward", n_fwd, 1);
		check("jog reverse", n_rev, 1);
		check("no edit in jog", n_inc + n_dec, 3);

		@(posedge clk);
		cpow <= 1'b1;
		servo <= 1'b1;
		ctrl <= panel_pkg::CTRL_SPEED;
		spd <= 16'sd25;
		cmd <= 16'sd30;
		settle();
		check("control power", cps, 1);
		check("power ready", prs, 0);
		check("base block", bbs, 0);
		check("speed match near", sms, 1);
		check("rotation above", rds, 1);
		check("speed cmd above", cis, 1);
		@(posedge clk);
		cpow <= 1'b0;
		mpow <= 1'b1;
		servo <= 1'b0;
		spd <= 16'sd20;
		cmd <= 16'sd9;
		settle();
		check("control power off", cps, 0);
		check("power ready on", prs, 1);
		check("base block on", bbs, 1);
		check("speed match far", sms, 0);
		check("rotation at limit", rds, 0);
		check("speed cmd below", cis, 0);
		@(posedge clk);
		lin <= 1'b1;
		settle();
		check("linear match", sms, 1);
		check("linear rotation", rds, 1);
		check("linear cmd", cis, 1);
		@(posedge clk);
		ctrl <= panel_pkg::CTRL_POSITION;
		dev <= -32'sd7;
		pulse <= 1'b1;
		clr <= 1'b1;
		settle();
		check("position done", pds, 1);
		check("pulses arriving", cis, 1);
		check("clear input", cls, 1);
		@(posedge clk);
		dev <= 32'sd8;
		pulse <= 1'b0;
		clr <= 1'b0;
		settle();
		check("position not done", pds, 0);
		check("no pulses", cis, 0);
		check("clear idle", cls, 0);
		@(posedge clk);
		pdw <= 32'h0000_0008;
		settle();
		check("wider window", pds, 1);
		@(posedge clk);
		ctrl <= panel_pkg::CTRL_TORQUE;
		trq <= 16'sd11;
		settle();
		check("torque above", cis, 1);
		check("torque match lit", sms, 1);
		@(posedge clk);
		trq <= 16'sd10;
		settle();
		check("torque at limit", cis, 0);
		@(posedge clk);
		ctrl <= panel_pkg::CTRL_BUS;
		bus_a <= 2'h2;
		bus_b <= 2'h1;
		fstop <= 1'b1;
		noise <= 1'b1;
		settle();
		check("bus a", bas, 2'h2);
		check("bus b", bbo, 2'h1);
		check("forced stop", fss, 1);
		repeat (20)
		begin
			@(negedge clk);
			seen0 |= (nms === 1'b0);
			seen1 |= (nms === 1'b1);
		end
		check("noise blinks", {seen0, seen1}, 2'h3);

		do_reset(12'h123);
		check("power-up monitor", mode, panel_pkg::MODE_MONITOR);
		check("power-up item", item, 12'h123);
		final_report();
	end

	// The whole run needs a few hundred cycles; this leaves wide margin.
	initial
	begin
		#200000;
		mismatches++;
		final_report();
	end
endmodule : tb_panel_key_and_status_display
